//--- hw/dmt_params.svh
`ifndef DMT_PARAMS_SVH
`define DMT_PARAMS_SVH

// ****************************************************************
// register offsets on the i/o port
// ****************************************************************
`define DMT_OFS_STATUS   8'hb0
`define DMT_OFS_CTRL     8'hb1
`define DMT_OFS_M1_HIGH  8'hb2
`define DMT_OFS_M1_LOW   8'hb3
`define DMT_OFS_M2_HIGH  8'hb4
`define DMT_OFS_M2_LOW   8'hb5
`define DMT_OFS_CNT_HIGH 8'hbe
`define DMT_OFS_CNT_LOW  8'hbf

// ****************************************************************
// field positions
// ****************************************************************
`define DMT_SB_RUN       0
`define DMT_SB_CH1       1
`define DMT_SB_CH2       2
`define DMT_SB_TOP       2
`define DMT_CB_TOP       3
`define DMT_HB_LSB       6

// ****************************************************************
// reset values and counts
// ****************************************************************
`define DMT_STATUS_RST   3'h0
`define DMT_CTRL_RST     4'h0
`define DMT_CNT_W        10
`define DMT_SLOW_DIV     8

`endif

//--- hw/dmt_pkg.sv
package dmt_pkg;

	// ****************************************************************
	// register carriers
	// ****************************************************************
	typedef struct packed {
		logic ien2;
		logic ien1;
		logic run;
	} dmt_status_s;

	typedef struct packed {
		logic [1:0] src;
		logic [1:0] prio;
	} dmt_ctrl_s;

	typedef enum logic [1:0] {
		DMT_SRC_HALF = 2'h0,
		DMT_SRC_SUB  = 2'h1
	} dmt_src_e;

	// address decode shared by every register strobe
	function automatic logic dmt_hit(input logic [7:0] addr,
		input logic [7:0] ofs);
		return addr == ofs;
	endfunction : dmt_hit

endpackage : dmt_pkg

//--- hw/dmt_compare.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmt_params.svh"

module dmt_compare #(
	parameter int CNT_W = `DMT_CNT_W
) (
	input  wire logic             clk_i,    // peripheral clock
	input  wire logic             rst_n_i,  // sync reset, low
	input  wire logic             step_i,   // counter advances now
	input  wire logic [CNT_W-1:0] next_i,   // value counter steps to
	input  wire logic             wr_hi_i,  // high preload write
	input  wire logic             wr_lo_i,  // low preload write
	input  wire logic [7:0]       wdata_i,  // write data
	output logic                  pulse_o,  // one-clock match pulse
	output logic                  fire_o,   // pulse while armed
	output logic                  armed_o,  // low preload valid
	output logic [CNT_W-1:0]      match_o   // active match value
);

	logic [CNT_W-9:0] hi_q;
	logic [7:0]       lo_q;
	logic [CNT_W-1:0] match_q;
	logic             armed_q;
	logic             pulse_q;
	wire              hit;

	assign hit     = step_i && (next_i == match_q);
	assign pulse_o = pulse_q;
	// flag must rise on the same edge as the port strobe
	assign fire_o  = hit && armed_q;
	assign armed_o = armed_q;
	assign match_o = match_q;

	// ****************************************************************
	// preloads
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			hi_q <= '0;
			lo_q <= '0;
		end else begin
			if (wr_hi_i)
				hi_q <= wdata_i[7:`DMT_HB_LSB];
			if (wr_lo_i)
				lo_q <= wdata_i;
		end
	end

	// ****************************************************************
	// comparator
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			match_q <= '0;
			pulse_q <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			pulse_q <= hit;
			if (hit)
				match_q <= {hi_q, lo_q};
			if (wr_lo_i)
				armed_q <= 1'b1;
			else if (hit)
				armed_q <= 1'b0;
		end
	end

endmodule : dmt_compare

`default_nettype wire

//--- hw/dmt_timer.sv
// What this block does
// - counter source: half, slow, subtimer
// - 10-bit counter free-runs and wraps
// - two match registers compared each step
// - equal step gives one-clock pulse
// - pulse feeds port strobe; only a match while low preload valid feeds interrupt
// - preload moves to match on pulse
// - match invalidates low preload until rewritten
// - status read clears flags, keeps enables
// - status bits 7:3 read zero
// - status bits 2,1 show matches taken while low preload valid
// - status write bits 2,1 enable interrupts
// - status bit 0 runs the counter
// - reset clears status low bits
// - reset clears control low nibble
// - control bits 3:2 pick clock
// - high preload keeps bits 7:6
// - live count readable in two bytes
`timescale 1ns/1ps
`default_nettype none
`include "dmt_params.svh"

module dmt_timer
	import dmt_pkg::*;
#(
	parameter int CNT_W    = `DMT_CNT_W,
	parameter int SLOW_DIV = `DMT_SLOW_DIV
) (
	input  wire logic       clk_i,          // peripheral clock
	input  wire logic       rst_n_i,        // sync reset, low
	input  wire logic [7:0] io_addr_i,      // i/o register address
	input  wire logic       io_wr_i,        // write strobe
	input  wire logic       io_rd_i,        // read strobe
	input  wire logic [7:0] io_wdata_i,     // write data
	output logic [7:0]      io_rdata_o,     // read data, next cycle
	input  wire logic       sub_tick_i,     // other timer subtimer
	output logic [1:0]      match_pulse_o,  // port strobes per channel
	output logic [1:0]      irq_o,          // interrupt requests
	output logic [1:0]      irq_priority_o  // priority level
);

	localparam int SW = $clog2(SLOW_DIV);

	// ****************************************************************
	// state
	// ****************************************************************
	dmt_status_s      status_q;
	dmt_ctrl_s        ctrl_q;
	logic [CNT_W-1:0] cnt_q;
	logic             half_q;
	logic [SW-1:0]    slow_q;
	logic [1:0]       flag_q;
	logic [7:0]       rdata_q;

	wire [CNT_W-1:0]  cnt_next;
	wire              half_tick;
	wire              slow_tick;
	wire              src_tick;
	wire              step;
	wire [1:0]        pulse;
	wire [1:0]        fire;
	wire [1:0]        armed;
	wire [CNT_W-1:0]  match1;
	wire [CNT_W-1:0]  match2;
	wire              sel_status;
	wire              sel_ctrl;
	wire              sel_cnt_hi;
	wire              sel_cnt_lo;
	wire              rd_status;
	wire [1:0]        wr_hi;
	wire [1:0]        wr_lo;
	wire [7:0]        rd_value;
	wire              prio_on;

	// ****************************************************************
	// address decode
	// ****************************************************************
	assign sel_status = dmt_hit(io_addr_i, `DMT_OFS_STATUS);
	assign sel_ctrl   = dmt_hit(io_addr_i, `DMT_OFS_CTRL);
	assign sel_cnt_hi = dmt_hit(io_addr_i, `DMT_OFS_CNT_HIGH);
	assign sel_cnt_lo = dmt_hit(io_addr_i, `DMT_OFS_CNT_LOW);
	assign rd_status  = io_rd_i && sel_status;
	assign wr_hi[0]   = io_wr_i && dmt_hit(io_addr_i, `DMT_OFS_M1_HIGH);
	assign wr_lo[0]   = io_wr_i && dmt_hit(io_addr_i, `DMT_OFS_M1_LOW);
	assign wr_hi[1]   = io_wr_i && dmt_hit(io_addr_i, `DMT_OFS_M2_HIGH);
	assign wr_lo[1]   = io_wr_i && dmt_hit(io_addr_i, `DMT_OFS_M2_LOW);

	// ****************************************************************
	// clock source
	// ****************************************************************
	assign half_tick = half_q;
	assign slow_tick = half_tick && (slow_q == SW'(SLOW_DIV - 1));
	assign src_tick  = ctrl_q.src[1] ? slow_tick :
		(ctrl_q.src == DMT_SRC_SUB) ? sub_tick_i : half_tick;
	assign step      = src_tick && status_q.run;
	assign cnt_next  = cnt_q + 1'b1;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			half_q <= 1'b0;
			slow_q <= '0;
		end else begin
			half_q <= ~half_q;
			if (half_tick)
				slow_q <= slow_q + 1'b1;
		end
	end

	// ****************************************************************
	// counter
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			cnt_q <= '0;
		else if (step)
			cnt_q <= cnt_next;
	end

	// ****************************************************************
	// compare channels
	// ****************************************************************
	dmt_compare #(
		.CNT_W(CNT_W)
	) u_ch1 (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.step_i  (step),
		.next_i  (cnt_next),
		.wr_hi_i (wr_hi[0]),
		.wr_lo_i (wr_lo[0]),
		.wdata_i (io_wdata_i),
		.pulse_o (pulse[0]),
		.fire_o  (fire[0]),
		.armed_o (armed[0]),
		.match_o (match1)
	);

	dmt_compare #(
		.CNT_W(CNT_W)
	) u_ch2 (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.step_i  (step),
		.next_i  (cnt_next),
		.wr_hi_i (wr_hi[1]),
		.wr_lo_i (wr_lo[1]),
		.wdata_i (io_wdata_i),
		.pulse_o (pulse[1]),
		.fire_o  (fire[1]),
		.armed_o (armed[1]),
		.match_o (match2)
	);

	assign match_pulse_o = pulse;

	// ****************************************************************
	// control registers
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			status_q <= `DMT_STATUS_RST;
			ctrl_q   <= `DMT_CTRL_RST;
		end else begin
			if (io_wr_i && sel_status)
				status_q <= io_wdata_i[`DMT_SB_TOP:0];
			if (io_wr_i && sel_ctrl)
				ctrl_q <= io_wdata_i[`DMT_CB_TOP:0];
		end
	end

	// ****************************************************************
	// match flags and interrupts
	// ****************************************************************
	// a match landing on the clearing read stays pending
	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			flag_q <= 2'h0;
		else
			flag_q <= fire | (rd_status ? 2'h0 : flag_q);
	end

	assign prio_on        = |ctrl_q.prio;
	assign irq_o[0]       = flag_q[0] && status_q.ien1 && prio_on;
	assign irq_o[1]       = flag_q[1] && status_q.ien2 && prio_on;
	assign irq_priority_o = ctrl_q.prio;

	// ****************************************************************
	// read path
	// ****************************************************************
	assign rd_value =
		sel_status ? {5'h00, flag_q, 1'b0} :
		sel_cnt_hi ? {cnt_q[CNT_W-1:8], 6'h00} :
		sel_cnt_lo ? cnt_q[7:0] : 8'h00;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			rdata_q <= 8'h00;
		else if (io_rd_i)
			rdata_q <= rd_value;
	end

	assign io_rdata_o = rdata_q;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_half_rate;
		ctrl_q.src == 2'h0 && step |=> !step || ctrl_q.src != 2'h0;
	endproperty
	a_half_rate: assert property (p_half_rate)
		else $error("half-rate source stepped twice in a row");

	property p_wrap;
		step && &cnt_q |=> cnt_q == '0;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("counter did not wrap to zero");

	property p_stopped;
		!status_q.run |=> $stable(cnt_q);
	endproperty
	a_stopped: assert property (p_stopped)
		else $error("counter moved while stopped");

	property p_cause;
		step && cnt_next == match1 |=> pulse[0];
	endproperty
	a_cause: assert property (p_cause)
		else $error("match step gave no pulse");

	property p_one_clock;
		pulse[1] |=> !pulse[1];
	endproperty
	a_one_clock: assert property (p_one_clock)
		else $error("match pulse longer than one clock");

	property p_invalid;
		pulse[0] && !$past(wr_lo[0]) |-> !armed[0];
	endproperty
	a_invalid: assert property (p_invalid)
		else $error("low preload still valid after match");

	property p_read_clear;
		rd_status && fire == 2'h0 |=> flag_q == 2'h0 && $stable(status_q);
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("status read did not clear flags");

	property p_zero_top;
		rd_status |=> io_rdata_o[7:3] == 5'h00 && io_rdata_o[0] == 1'b0;
	endproperty
	a_zero_top: assert property (p_zero_top)
		else $error("status upper bits not zero");

	property p_flag_show;
		rd_status ##0 flag_q[1] |=> io_rdata_o[2];
	endproperty
	a_flag_show: assert property (p_flag_show)
		else $error("second channel match not reported");

	property p_irq;
		irq_o[0] |-> flag_q[0] && irq_priority_o != 2'h0;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt without flag or priority");

	property p_reset_state;
		$rose(rst_n_i) |-> status_q == 3'h0 && ctrl_q == 4'h0;
	endproperty
	a_reset_state: assert property (p_reset_state)
		else $error("control not cleared by reset");

	property p_live_count;
		io_rd_i && sel_cnt_lo |=> io_rdata_o == $past(cnt_q[7:0]);
	endproperty
	a_live_count: assert property (p_live_count)
		else $error("count low readback wrong");

	property p_sub_src;
		status_q.run && ctrl_q.src == 2'h1 && sub_tick_i
			|=> cnt_q == $past(cnt_q) + 1'b1;
	endproperty
	a_sub_src: assert property (p_sub_src)
		else $error("subtimer tick did not advance the counter");

	property p_slow_gap;
		ctrl_q.src[1] && step |=> (!step || !ctrl_q.src[1]) [*8];
	endproperty
	a_slow_gap: assert property (p_slow_gap)
		else $error("slow source stepped too often");

	property p_one_clock_a;
		pulse[0] |=> !pulse[0];
	endproperty
	a_one_clock_a: assert property (p_one_clock_a)
		else $error("first channel pulse longer than one clock");

	property p_cause_b;
		step && cnt_next == match2 |=> pulse[1];
	endproperty
	a_cause_b: assert property (p_cause_b)
		else $error("second channel match step gave no pulse");

	property p_pulse_why;
		pulse[0] |-> $past(step) && cnt_q == $past(match1);
	endproperty
	a_pulse_why: assert property (p_pulse_why)
		else $error("pulse without a matching step");

	property p_flag_set;
		pulse[1] && $past(armed[1]) |-> flag_q[1];
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("armed match did not raise its flag");

	property p_stay_idle;
		!armed[0] && !wr_lo[0] |=> !armed[0];
	endproperty
	a_stay_idle: assert property (p_stay_idle)
		else $error("low preload valid without a write");

	property p_prio_gate;
		ctrl_q.prio == 2'h0 |-> irq_o == 2'h0;
	endproperty
	a_prio_gate: assert property (p_prio_gate)
		else $error("interrupt raised with priority zero");

	property p_ctrl_write;
		io_wr_i && sel_ctrl |=> ctrl_q == $past(io_wdata_i[`DMT_CB_TOP:0]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write)
		else $error("control write not taken");

	property p_status_write;
		io_wr_i && sel_status
			|=> status_q == $past(io_wdata_i[`DMT_SB_TOP:0]);
	endproperty
	a_status_write: assert property (p_status_write)
		else $error("status write not taken");

	property p_high_count;
		io_rd_i && sel_cnt_hi
			|=> io_rdata_o == {$past(cnt_q[CNT_W-1:8]), 6'h00};
	endproperty
	a_high_count: assert property (p_high_count)
		else $error("count high readback wrong");

endmodule : dmt_timer

`default_nettype wire

//--- bench/dmt_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmt_params.svh"

module dmt_timer_bench;

	// ****************************************************************
	// clock, design and scoreboard
	// ****************************************************************
	logic       clk_i      = 1'b0;
	logic       rst_n_i    = 1'b0;
	logic [7:0] io_addr_i  = 8'h00;
	logic       io_wr_i    = 1'b0;
	logic       io_rd_i    = 1'b0;
	logic [7:0] io_wdata_i = 8'h00;
	logic       sub_tick_i = 1'b0;
	logic [7:0] io_rdata_o;
	logic [1:0] match_pulse_o;
	logic [1:0] irq_o;
	logic [1:0] irq_priority_o;
	logic [7:0] exp_q[$];
	logic       rd_seen    = 1'b0;
	int         err_count  = 0;
	int         tests_run  = 0;
	logic [7:0] dead_addr [4] = '{8'hb1, 8'hb2, 8'hb5, 8'ha0};

	always #20 clk_i = ~clk_i;

	dmt_timer dut (
		.clk_i          (clk_i),
		.rst_n_i        (rst_n_i),
		.io_addr_i      (io_addr_i),
		.io_wr_i        (io_wr_i),
		.io_rd_i        (io_rd_i),
		.io_wdata_i     (io_wdata_i),
		.io_rdata_o     (io_rdata_o),
		.sub_tick_i     (sub_tick_i),
		.match_pulse_o  (match_pulse_o),
		.irq_o          (irq_o),
		.irq_priority_o (irq_priority_o)
	);

	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		tests_run++;
		if (seen !== want) begin
			err_count++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : chk

	// read data lands one edge after the strobe is taken
	always @(posedge clk_i) begin
		if (rd_seen)
			chk(16'(io_rdata_o), 16'(exp_q.pop_front()));
		rd_seen = io_rd_i;
	end

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish

	// ****************************************************************
	// bus and stimulus tasks
	// ****************************************************************
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		io_addr_i  <= a;
		io_wdata_i <= d;
		io_wr_i    <= 1'b1;
		@(posedge clk_i);
		io_wr_i <= 1'b0;
		@(posedge clk_i);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		io_addr_i <= a;
		io_rd_i   <= 1'b1;
		@(posedge clk_i);
		io_rd_i <= 1'b0;
		@(posedge clk_i);
	endtask : rd

	task automatic reset_dut;
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
	endtask : reset_dut

	task automatic tick;
		sub_tick_i <= 1'b1;
		@(posedge clk_i);
		sub_tick_i <= 1'b0;
		@(posedge clk_i);
	endtask : tick

	task automatic wait_pulse(input int ch, input int lim, output int n);
		n = 0;
		while (match_pulse_o[ch] !== 1'b1 && n < lim) begin
			@(posedge clk_i);
			n++;
		end
		chk(16'(n < lim), 16'h0001);
	endtask : wait_pulse

	// ****************************************************************
	// tests
	// ****************************************************************
	task automatic count_test;
		int n;
		n = $urandom_range(1, 700);
		reset_dut();
		chk(16'(irq_priority_o), 16'h0000);
		chk(16'(irq_o), 16'h0000);
		rd(`DMT_OFS_STATUS, 8'h00);
		wr(`DMT_OFS_CTRL, 8'h04);
		wr(`DMT_OFS_STATUS, 8'h01);
		repeat (n) tick();
		wr(`DMT_OFS_STATUS, 8'h00);
		repeat (5) tick();
		wr(`DMT_OFS_CNT_LOW, 8'hff);
		rd(`DMT_OFS_CNT_LOW, 8'(n));
		rd(`DMT_OFS_CNT_HIGH, {2'(n >> 8), 6'h00});
		foreach (dead_addr[i])
			rd(dead_addr[i], 8'h00);
		for (int p = 0; p < 4; p++) begin
			wr(`DMT_OFS_CTRL, 8'(p));
			chk(16'(irq_priority_o), 16'(p));
		end
		$display("test count done");
	endtask : count_test

	task automatic chan_test(input int ch, input logic [1:0] src,
		input int div, input logic [1:0] top);
		logic [7:0] lo;
		logic [7:0] flag;
		logic [1:0] pr;
		logic [7:0] lo_ofs;
		int         n;
		lo     = 8'($urandom_range(8, 200));
		pr     = 2'($urandom_range(1, 3));
		flag   = ch ? 8'h04 : 8'h02;
		lo_ofs = ch ? `DMT_OFS_M2_LOW : `DMT_OFS_M1_LOW;
		reset_dut();
		wr(`DMT_OFS_CTRL, {4'h0, src, pr});
		chk(16'(irq_priority_o), 16'(pr));
		wr(ch ? `DMT_OFS_M2_HIGH : `DMT_OFS_M1_HIGH, {top, 6'($urandom)});
		wr(lo_ofs, lo);
		wr(`DMT_OFS_STATUS, flag | 8'h01);
		wait_pulse(ch, 1100 * div, n);
		chk(16'(irq_o[ch]), 16'h0001);
		@(posedge clk_i);
		chk(16'(match_pulse_o[ch]), 16'h0000);
		rd(`DMT_OFS_STATUS, flag);
		chk(16'(irq_o[ch]), 16'h0000);
		wait_pulse(ch, 1100 * div, n);
		chk(16'(n + 3), 16'({top, lo} * div));
		rd(`DMT_OFS_STATUS, 8'h00);
		wr(lo_ofs, lo);
		wait_pulse(ch, 1100 * div, n);
		chk(16'(n + 4), 16'(1024 * div));
		chk(16'(irq_o[ch]), 16'h0001);
		rd(`DMT_OFS_STATUS, flag);
		$display("test channel %0d done", ch);
	endtask : chan_test

	initial begin
		void'($urandom(32'h0158));
		count_test();
		chan_test(0, 2'b00, 2, 2'($urandom));
		chan_test(1, 2'b11, 16, 2'b00);
		tally_and_finish();
	end

	initial begin
		repeat (60000) @(posedge clk_i);
		err_count++;
		tally_and_finish();
	end

endmodule : dmt_timer_bench

`default_nettype wire
